// ==== bififo_parity_map.vh ====
// Constants for the read-path parity generator: word layout and reset values.
`ifndef BIFIFO_PARITY_MAP_VH
`define BIFIFO_PARITY_MAP_VH
`define BPG_WORD_W       36
`define BPG_BYTE_W       9
`define BPG_BYTE_N       4
`define BPG_CTRL_W       5
`define BPG_CTRL_SEL_N   4
`define BPG_CTRL_DIR     3
`define BPG_CTRL_MAIL    2
`define BPG_CTRL_GATE    1
`define BPG_CTRL_PGEN    0
`define BPG_CTRL_RST     5'h10
`define BPG_WORD_RST     36'h000000000
`endif

// ==== word_parity.v ====
// Four byte parity trees over one 36-bit word: generate and check.
`include "bififo_parity_map.vh"
module word_parity #(
   parameter BYTE_W = `BPG_BYTE_W,
   parameter BYTE_N = `BPG_BYTE_N
) (
   // Word to examine.
   input  wire [BYTE_W*BYTE_N-1:0] word,
   // High selects odd parity, low selects even parity.
   input  wire                     odd_sel,
   // Word with each byte top bit replaced by generated parity.
   output wire [BYTE_W*BYTE_N-1:0] gen_word,
   // High when any byte fails the selected sense.
   output wire                     fault
);
   wire [BYTE_N-1:0] byte_bad;  // Per-byte check failures.
   genvar i;
   generate
      for (i = 0; i < BYTE_N; i = i + 1) begin : g_byte
         // Parity of the eight data bits of this byte.
         wire low_par = ^word[i*BYTE_W +: BYTE_W-1];
         // Odd sense needs the top bit to make the ones count odd.
         assign gen_word[i*BYTE_W +: BYTE_W-1] = word[i*BYTE_W +: BYTE_W-1];
         assign gen_word[i*BYTE_W+BYTE_W-1]    = low_par ^ odd_sel;
         // A byte fails when its nine bits do not match the selected sense.
         assign byte_bad[i] = (^word[i*BYTE_W +: BYTE_W]) ^ odd_sel;
      end
   endgenerate
   assign fault = |byte_bad;
endmodule // word_parity

// ==== bififo_read_parity_generator.v ====
// Read-path parity generation and input checking for both ports of a dual FIFO.
//
// Notes on behaviour
// RL1: Generate select high makes parity on port reads.
// RL2: Word is four nine-bit bytes, top bit parity.
// RL3: Writes store all 36 levels untouched.
// RL4: Parity from lower eight bits, odd/even selectable.
// RL5: Generated bits replace stored top bits on output.
// RL6: FIFO parity made before output register load.
// RL7: Outside holds selects stable around load edges.
// RL8: Mail trees shared with opposite-port input checkers.
// RL9: Mail parity only on selected, enabled, generating read.
// RL10: Mail contents unchanged by generating parity.
// RL11: Outside encodes FIFO read and write selects.
// RL12: Output from FIFO register or mail register.
// RL13: Fault flag held high on generating mail read.
// RL14: Generated byte matches checker parity convention.
`include "bififo_parity_map.vh"
module bififo_read_parity_generator #(
   parameter WORD_W = `BPG_WORD_W
) (
   // Clock and reset.
   input  wire              clk_sys,
   input  wire              reset_n,
   // Shared parity sense pin, high for odd.
   input  wire              odd_even_sel,
   // Port A control pins.
   input  wire              port_a_select_n,
   input  wire              port_a_direction,
   input  wire              port_a_mail_choose,
   input  wire              port_a_transfer_gate,
   input  wire              port_a_parity_gen_sel,
   // Port A data pins and their drive.
   input  wire [WORD_W-1:0] port_a_data_in,
   output reg  [WORD_W-1:0] port_a_data_out,
   output reg               port_a_data_oe,
   output reg               port_a_parity_fault_n,
   // Port A side of FIFO1 write and FIFO2 read.
   output reg               port_a_fifo_wr_en,
   output reg  [WORD_W-1:0] port_a_fifo_wr_data,
   input  wire              port_a_fifo_load,
   input  wire [WORD_W-1:0] port_a_fifo_ram_data,
   // Port B control pins.
   input  wire              port_b_select_n,
   input  wire              port_b_direction,
   input  wire              port_b_mail_choose,
   input  wire              port_b_transfer_gate,
   input  wire              port_b_parity_gen_sel,
   // Port B data pins and their drive.
   input  wire [WORD_W-1:0] port_b_data_in,
   output reg  [WORD_W-1:0] port_b_data_out,
   output reg               port_b_data_oe,
   output reg               port_b_parity_fault_n,
   // Port B side of FIFO2 write and FIFO1 read.
   output reg               port_b_fifo_wr_en,
   output reg  [WORD_W-1:0] port_b_fifo_wr_data,
   input  wire              port_b_fifo_load,
   input  wire [WORD_W-1:0] port_b_fifo_ram_data
);
   localparam CW   = `BPG_CTRL_W;
   localparam SYNW = 2*CW + 2*WORD_W + 1;  // Width of all pin inputs together.

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   ////////////////////////////////////////////////////////////////////////////
   wire [SYNW-1:0] pins_raw = {odd_even_sel,
      port_a_select_n, port_a_direction, port_a_mail_choose, port_a_transfer_gate,
      port_a_parity_gen_sel, port_a_data_in,
      port_b_select_n, port_b_direction, port_b_mail_choose, port_b_transfer_gate,
      port_b_parity_gen_sel, port_b_data_in};
   reg  [SYNW-1:0] pins_meta_q;  // First stage, read only by the second.
   reg  [SYNW-1:0] pins_q;       // Second stage, safe to use.
   localparam [SYNW-1:0] PINS_RST = {1'b0, `BPG_CTRL_RST, `BPG_WORD_RST,
                                     `BPG_CTRL_RST, `BPG_WORD_RST};

   // Two flip-flops in series on every pin input.
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pins_meta_q <= PINS_RST;
         pins_q      <= PINS_RST;
      end else begin
         pins_meta_q <= pins_raw;
         pins_q      <= pins_meta_q;
      end
   end

   // Split the synchronised bundle back into named signals.
   wire              odd_s  = pins_q[SYNW-1];
   wire [CW-1:0]     ctl_a  = pins_q[SYNW-2 -: CW];
   wire [WORD_W-1:0] din_a  = pins_q[SYNW-2-CW -: WORD_W];
   wire [CW-1:0]     ctl_b  = pins_q[CW+WORD_W-1 -: CW];
   wire [WORD_W-1:0] din_b  = pins_q[WORD_W-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // Decode of the port selects.
   ////////////////////////////////////////////////////////////////////////////
   // A port is active when selected low and its transfer gate is high.
   wire act_a = ~ctl_a[`BPG_CTRL_SEL_N] & ctl_a[`BPG_CTRL_GATE];
   wire act_b = ~ctl_b[`BPG_CTRL_SEL_N] & ctl_b[`BPG_CTRL_GATE];
   // Write means direction high, read means direction low.
   wire wr_a  = act_a & ctl_a[`BPG_CTRL_DIR];
   wire wr_b  = act_b & ctl_b[`BPG_CTRL_DIR];
   // Shared trees generate mail parity only on a selected mail read.
   wire mgen_a = act_a & ~ctl_a[`BPG_CTRL_DIR] & ctl_a[`BPG_CTRL_MAIL]
                 & ctl_a[`BPG_CTRL_PGEN];  // RL9
   wire mgen_b = act_b & ~ctl_b[`BPG_CTRL_DIR] & ctl_b[`BPG_CTRL_MAIL]
                 & ctl_b[`BPG_CTRL_PGEN];  // RL9

   ////////////////////////////////////////////////////////////////////////////
   // Mail registers, written from one port and read from the other.
   ////////////////////////////////////////////////////////////////////////////
   reg [WORD_W-1:0] mail1_q;  // Written by port A, read by port B.
   reg [WORD_W-1:0] mail2_q;  // Written by port B, read by port A.

   // Raw levels are stored; reads and parity generation never write back.
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mail1_q <= `BPG_WORD_RST;
         mail2_q <= `BPG_WORD_RST;
      end else begin
         if (wr_a && ctl_a[`BPG_CTRL_MAIL]) begin
            mail1_q <= din_a;  // RL3 RL10
         end
         if (wr_b && ctl_b[`BPG_CTRL_MAIL]) begin
            mail2_q <= din_b;  // RL3 RL10
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Parity trees.
   ////////////////////////////////////////////////////////////////////////////
   // Port A trees check the A bus, or make parity for mail2 when reading it.
   wire [WORD_W-1:0] tree_a_in = mgen_a ? mail2_q : din_a;  // RL8
   wire [WORD_W-1:0] tree_b_in = mgen_b ? mail1_q : din_b;  // RL8
   wire [WORD_W-1:0] tree_a_gen;
   wire [WORD_W-1:0] tree_b_gen;
   wire              tree_a_bad;
   wire              tree_b_bad;
   wire [WORD_W-1:0] fifo_a_gen;
   wire [WORD_W-1:0] fifo_b_gen;

   // Shared trees of port A: bus check and mail2 generation.
   word_parity u_tree_a (
      .word     (tree_a_in),
      .odd_sel  (odd_s),
      .gen_word (tree_a_gen),
      .fault    (tree_a_bad)
   );  // RL2 RL4 RL14

   // Shared trees of port B: bus check and mail1 generation.
   word_parity u_tree_b (
      .word     (tree_b_in),
      .odd_sel  (odd_s),
      .gen_word (tree_b_gen),
      .fault    (tree_b_bad)
   );  // RL2 RL4 RL14

   // Trees between the FIFO2 array read and the port A output register.
   word_parity u_fifo_a (
      .word     (port_a_fifo_ram_data),
      .odd_sel  (odd_s),
      .gen_word (fifo_a_gen),
      .fault    ()
   );  // RL6

   // Trees between the FIFO1 array read and the port B output register.
   word_parity u_fifo_b (
      .word     (port_b_fifo_ram_data),
      .odd_sel  (odd_s),
      .gen_word (fifo_b_gen),
      .fault    ()
   );  // RL6

   ////////////////////////////////////////////////////////////////////////////
   // FIFO output registers.
   ////////////////////////////////////////////////////////////////////////////
   reg [WORD_W-1:0] fifo_out_a_q;  // Port A FIFO output register.
   reg [WORD_W-1:0] fifo_out_b_q;  // Port B FIFO output register.

   // Select and sense are sampled only on the edge that loads a new word.
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         fifo_out_a_q <= `BPG_WORD_RST;
         fifo_out_b_q <= `BPG_WORD_RST;
      end else begin
         if (port_a_fifo_load) begin
            fifo_out_a_q <= ctl_a[`BPG_CTRL_PGEN] ? fifo_a_gen
                                                  : port_a_fifo_ram_data;  // RL1 RL5 RL6 RL7
         end
         if (port_b_fifo_load) begin
            fifo_out_b_q <= ctl_b[`BPG_CTRL_PGEN] ? fifo_b_gen
                                                  : port_b_fifo_ram_data;  // RL1 RL5 RL6 RL7
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port outputs, flags and FIFO write path.
   ////////////////////////////////////////////////////////////////////////////
   // All outputs are registered; the drive follows a selected read.
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         port_a_data_out       <= `BPG_WORD_RST;
         port_a_data_oe        <= 1'b0;
         port_a_parity_fault_n <= 1'b1;
         port_a_fifo_wr_en     <= 1'b0;
         port_a_fifo_wr_data   <= `BPG_WORD_RST;
         port_b_data_out       <= `BPG_WORD_RST;
         port_b_data_oe        <= 1'b0;
         port_b_parity_fault_n <= 1'b1;
         port_b_fifo_wr_en     <= 1'b0;
         port_b_fifo_wr_data   <= `BPG_WORD_RST;
      end else begin
         // Outputs are driven while the port is selected for reading.
         port_a_data_oe <= ~ctl_a[`BPG_CTRL_SEL_N] & ~ctl_a[`BPG_CTRL_DIR];
         port_b_data_oe <= ~ctl_b[`BPG_CTRL_SEL_N] & ~ctl_b[`BPG_CTRL_DIR];
         // Mail choose picks the mail register, otherwise the FIFO register.
         if (ctl_a[`BPG_CTRL_MAIL]) begin
            port_a_data_out <= mgen_a ? tree_a_gen : mail2_q;  // RL12 RL5 RL1
         end else begin
            port_a_data_out <= fifo_out_a_q;  // RL12
         end
         if (ctl_b[`BPG_CTRL_MAIL]) begin
            port_b_data_out <= mgen_b ? tree_b_gen : mail1_q;  // RL12 RL5 RL1
         end else begin
            port_b_data_out <= fifo_out_b_q;  // RL12
         end
         // The flag is held high while the trees serve a mail read.
         port_a_parity_fault_n <= mgen_a | ~tree_a_bad;  // RL13
         port_b_parity_fault_n <= mgen_b | ~tree_b_bad;  // RL13
         // FIFO writes pass the raw 36 levels, whatever the generate select.
         port_a_fifo_wr_en   <= wr_a & ~ctl_a[`BPG_CTRL_MAIL];  // RL11
         port_a_fifo_wr_data <= din_a;  // RL3
         port_b_fifo_wr_en   <= wr_b & ~ctl_b[`BPG_CTRL_MAIL];  // RL11
         port_b_fifo_wr_data <= din_b;  // RL3
      end
   end
endmodule // bififo_read_parity_generator

// ==== bififo_read_parity_monitor_monitor.sv ====
// Checker for port timing and generated parity of the parity generator.
module bififo_read_parity_monitor (
   // Clock, reset and parity sense.
   input wire        clk_sys,
   input wire        reset_n,
   input wire        odd_even_sel,
   // Port A pins and array side.
   input wire        port_a_select_n,
   input wire        port_a_direction,
   input wire        port_a_mail_choose,
   input wire        port_a_transfer_gate,
   input wire        port_a_parity_gen_sel,
   input wire        port_a_data_oe,
   input wire        port_a_parity_fault_n,
   input wire        port_a_fifo_wr_en,
   input wire        port_a_fifo_load,
   input wire [35:0] port_a_data_in,
   input wire [35:0] port_a_data_out,
   input wire [35:0] port_a_fifo_wr_data,
   input wire [35:0] port_a_fifo_ram_data,
   // Port B pins.
   input wire        port_b_select_n,
   input wire        port_b_direction,
   input wire        port_b_mail_choose,
   input wire        port_b_transfer_gate,
   input wire        port_b_parity_gen_sel,
   input wire        port_b_data_oe,
   input wire        port_b_parity_fault_n,
   input wire        port_b_fifo_wr_en
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Edges since reset release, saturating at three. Until then the pin
   // synchronisers still hold reset values, so past pin levels do not apply.
   reg [1:0] up_q;
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         up_q <= 2'h0;
      end else if (up_q != 2'h3) begin
         up_q <= up_q + 2'h1;
      end
   end
   wire settled = (up_q == 2'h3);  // Pin history is valid again.
   // Decoded pin states, so that each past value is a single signal.
   wire rd_a = !port_a_select_n && !port_a_direction;
   wire rd_b = !port_b_select_n && !port_b_direction;
   wire fw_a = !port_a_select_n && port_a_direction && !port_a_mail_choose;
   wire fw_b = !port_b_select_n && port_b_direction && !port_b_mail_choose;
   wire mg_a = rd_a && port_a_mail_choose && port_a_transfer_gate && port_a_parity_gen_sel;
   wire mg_b = rd_b && port_b_mail_choose && port_b_transfer_gate && port_b_parity_gen_sel;
   // Rebuilds the top bit of each byte from its low eight bits.
   function [35:0] gw(input [35:0] w, input o);
      integer k;
      begin
         gw = w;
         for (k = 0; k < 4; k = k + 1) gw[9*k+8] = ^w[9*k +: 8] ^ o;
      end
   endfunction
   a_oe_port_a: assert property (settled |-> port_a_data_oe == $past(rd_a, 3))
      else $error("port A drive enable wrong");
   a_oe_port_b: assert property (settled |-> port_b_data_oe == $past(rd_b, 3))
      else $error("port B drive enable wrong");
   a_write_sel_a: assert property (port_a_fifo_wr_en |-> $past(fw_a, 3))
      else $error("port A write strobe without write select");
   a_write_sel_b: assert property (port_b_fifo_wr_en |-> $past(fw_b, 3))
      else $error("port B write strobe without write select");
   a_write_raw_a: assert property (port_a_fifo_wr_en |->
      port_a_fifo_wr_data == $past(port_a_data_in, 3)) else $error("port A write word altered");
   a_fault_held_a: assert property (settled && $past(mg_a, 3) |-> port_a_parity_fault_n)
      else $error("port A fault flag not held high");
   a_fault_held_b: assert property (settled && $past(mg_b, 3) |-> port_b_parity_fault_n)
      else $error("port B fault flag not held high");
   // The loaded word reaches the data outputs two edges after the load.
   a_fifo_out_a: assert property (settled && port_a_fifo_load && !$past(port_a_mail_choose) |->
      ##2 port_a_data_out == ($past(port_a_parity_gen_sel, 4) ?
      gw($past(port_a_fifo_ram_data, 2), $past(odd_even_sel, 4)) :
      $past(port_a_fifo_ram_data, 2)))
      else $error("port A FIFO word wrong");
endmodule // bififo_read_parity_monitor
bind bififo_read_parity_generator bififo_read_parity_monitor u_mon (
   .clk_sys(clk_sys), .reset_n(reset_n), .odd_even_sel(odd_even_sel),
   .port_a_select_n(port_a_select_n), .port_a_direction(port_a_direction),
   .port_a_mail_choose(port_a_mail_choose), .port_a_transfer_gate(port_a_transfer_gate),
   .port_a_parity_gen_sel(port_a_parity_gen_sel), .port_a_data_oe(port_a_data_oe),
   .port_a_parity_fault_n(port_a_parity_fault_n), .port_a_fifo_wr_en(port_a_fifo_wr_en),
   .port_a_fifo_load(port_a_fifo_load), .port_a_data_in(port_a_data_in),
   .port_a_data_out(port_a_data_out), .port_a_fifo_wr_data(port_a_fifo_wr_data),
   .port_a_fifo_ram_data(port_a_fifo_ram_data),
   .port_b_select_n(port_b_select_n), .port_b_direction(port_b_direction),
   .port_b_mail_choose(port_b_mail_choose), .port_b_transfer_gate(port_b_transfer_gate),
   .port_b_parity_gen_sel(port_b_parity_gen_sel), .port_b_data_oe(port_b_data_oe),
   .port_b_parity_fault_n(port_b_parity_fault_n), .port_b_fifo_wr_en(port_b_fifo_wr_en)
);

// ==== fifo_array_model.sv ====
// Behavioural FIFO array on the far side of one read port.
module fifo_array_model (
   // Clock.
   input  wire        clk_sys,
   // Raw words from the writing port.
   input  wire        wr_en,
   input  wire [35:0] wr_data,
   // Bench read request, load strobe and array word.
   input  wire        pop,
   output wire        load,
   output wire [35:0] ram_data
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [35:0] mem_q [0:7];   // Stored words.
   reg [2:0]  wptr_q = 3'h0; // Next write slot.
   reg [2:0]  rptr_q = 3'h0; // Oldest unread slot.
   // Outside a load the word is inverted so stale data never looks valid.
   assign load = pop;
   assign ram_data = pop ? mem_q[rptr_q] : ~mem_q[rptr_q];
   // Each write strobe stores one word unchanged; each load consumes one.
   always @(posedge clk_sys) begin
      if (wr_en) begin
         mem_q[wptr_q] <= wr_data;
         wptr_q <= wptr_q + 3'h1;
      end
      if (pop) rptr_q <= rptr_q + 3'h1;
   end
endmodule // fifo_array_model

// ==== bififo_read_parity_generator_tb.sv ====
// Self-checking bench for the read-path parity generator.
module bififo_read_parity_generator_tb;
   timeunit 1ns;
   timeprecision 1ns;
   reg         clk_sys = 1'b0;
   reg         reset_n = 1'b0;
   reg         odd_even_sel = 1'b0;
   reg  [4:0]  ca = 5'h10, cb = 5'h10; // Controls: select_n, direction, mail, gate, gen.
   reg  [35:0] da = 36'h0, db = 36'h0; // Bus input levels.
   reg         pop_a = 1'b0, pop_b = 1'b0;
   reg  [73:0] rows [0:3];             // Rows of expected word, odd, gen and stored word.
   wire [35:0] qa, qb, wda, wdb, ra, rb;
   wire        oea, oeb, fa, fb, wea, web, lda, ldb;
   integer     n_errors = 0, compares = 0, i;
   // Expected word: top bit of each byte regenerated when gen is set.
   function [35:0] pg(input [35:0] w, input g, input o);
      integer k;
      begin
         pg = w;
         for (k = 0; k < 4; k = k + 1) if (g) pg[9*k+8] = ^w[9*k +: 8] ^ o;
      end
   endfunction
   // Compares a seen value with an expected one.
   task chk(input [35:0] seen, input [35:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   // Drives both ports' pins at the next rising edge.
   task setc(input [4:0] a, input [4:0] b, input [35:0] x, input [35:0] y);
      begin
         @(posedge clk_sys);
         ca <= a;
         cb <= b;
         da <= x;
         db <= y;
      end
   endtask
   // Pulses one load strobe and waits for the output register.
   task pop(input s);
      begin
         @(posedge clk_sys);
         if (s) pop_b <= 1'b1; else pop_a <= 1'b1;
         @(posedge clk_sys);
         pop_a <= 1'b0;
         pop_b <= 1'b0;
         @(posedge clk_sys);
         #1;
      end
   endtask
   // Prints the verdict and ends the run.
   task final_report;
      begin
         if (n_errors == 0 && compares > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   bififo_read_parity_generator dut (.clk_sys(clk_sys), .reset_n(reset_n),
      .odd_even_sel(odd_even_sel), .port_a_select_n(ca[4]), .port_a_direction(ca[3]),
      .port_a_mail_choose(ca[2]), .port_a_transfer_gate(ca[1]), .port_a_parity_gen_sel(ca[0]),
      .port_a_data_in(da), .port_a_data_out(qa), .port_a_data_oe(oea),
      .port_a_parity_fault_n(fa), .port_a_fifo_wr_en(wea), .port_a_fifo_wr_data(wda),
      .port_a_fifo_load(lda), .port_a_fifo_ram_data(ra), .port_b_select_n(cb[4]),
      .port_b_direction(cb[3]), .port_b_mail_choose(cb[2]), .port_b_transfer_gate(cb[1]),
      .port_b_parity_gen_sel(cb[0]), .port_b_data_in(db), .port_b_data_out(qb),
      .port_b_data_oe(oeb), .port_b_parity_fault_n(fb), .port_b_fifo_wr_en(web),
      .port_b_fifo_wr_data(wdb), .port_b_fifo_load(ldb), .port_b_fifo_ram_data(rb));
   // FIFO1 runs from port A to port B, FIFO2 from port B to port A.
   fifo_array_model fifo1 (.clk_sys(clk_sys), .wr_en(wea), .wr_data(wda), .pop(pop_b),
      .load(ldb), .ram_data(rb));
   fifo_array_model fifo2 (.clk_sys(clk_sys), .wr_en(web), .wr_data(wdb), .pop(pop_a),
      .load(lda), .ram_data(ra));
   initial forever #20 clk_sys = ~clk_sys;
   // Main sequence: table rows first, then a FIFO1 read on port B, then mail, fault and reset cases.
   initial begin
      rows[0] = {36'h123456789, 2'h0, 36'h123456789};
      rows[1] = {36'h123476789, 2'h1, 36'h123456789};
      rows[2] = {36'h7edcba987, 2'h3, 36'hfedcba987};
      rows[3] = {36'h0ff00ff00, 2'h2, 36'h0ff00ff00};
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
         @(posedge clk_sys) odd_even_sel <= rows[i][37];
         setc({4'h1, rows[i][36]}, 5'h0a, 36'h0, rows[i][35:0]);
         setc({4'h1, rows[i][36]}, 5'h10, 36'h0, 36'h0);
         repeat (4) @(posedge clk_sys);
         pop(1'b0);
         chk(qa, rows[i][73:38]);
         chk({35'h0, oea}, 36'h1);
      end
      // FIFO1 word read out of port B with generation on.
      setc(5'h0a, 5'h11, 36'h5a5a5a5a5, 36'h0);
      setc(5'h10, 5'h11, 36'h0, 36'h0);
      repeat (4) @(posedge clk_sys);
      pop(1'b1);
      chk(qb, pg(36'h5a5a5a5a5, 1'b0 | 1'b1, rows[3][37]));
      // Mail1 written by port A, read by port B with gate and generate at 1/1, 0/1 and 1/0.
      @(posedge clk_sys) odd_even_sel <= 1'b1;
      setc(5'h0e, 5'h10, 36'h1ff00ff01, 36'h0);
      setc(5'h10, 5'h07, 36'h0, 36'h0);
      repeat (3) @(posedge clk_sys);
      #1;
      chk(qb, pg(36'h1ff00ff01, 1'b1, 1'b1));
      chk({35'h0, fb}, 36'h1);
      setc(5'h10, 5'h05, 36'h0, 36'h0);
      repeat (3) @(posedge clk_sys);
      #1;
      chk(qb, 36'h1ff00ff01);
      chk({35'h0, fb}, 36'h0);
      @(posedge clk_sys) odd_even_sel <= 1'b0;
      setc(5'h10, 5'h06, 36'h0, 36'h0);
      repeat (3) @(posedge clk_sys);
      #1;
      chk(qb, 36'h1ff00ff01);
      chk({35'h0, fb}, 36'h1);
      // Mail2 written by port B, read by port A with generation over a bad A bus.
      setc(5'h10, 5'h0e, 36'h0, 36'h0f0f0f0f0);
      setc(5'h07, 5'h10, 36'h000000001, 36'h0);
      repeat (3) @(posedge clk_sys);
      #1;
      chk(qa, pg(36'h0f0f0f0f0, 1'b1, 1'b0));
      chk({35'h0, fa}, 36'h1);
      // Reset in mid-run returns outputs to their idle levels.
      setc(5'h10, 5'h10, 36'h0, 36'h0);
      reset_n <= 1'b0;
      #1;
      chk({qb[31:0], oea, oeb, fa, fb}, 36'h3);
      @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      chk(qa, 36'h0);
      final_report;
   end
endmodule // bififo_read_parity_generator_tb
